// ==== rtl/msad_top.sv ====
// Purpose: Program and data space decode for a 16-bit core
// Assumes: Pipeline presents accesses and fetch requests on mclk
// Notes:   Data RAM held here; window and special regs are external
//
// Behaviour
// RL1: program word is lower even, upper odd
// RL2: pointer word aligned, steps by two
// RL3: 000000h to 0001FFh reserved for vectors
// RL4: reset starts at 000000h, jump operand 000002h
// RL5: two vector tables below 000200h
// RL6: top two words copied to config at reset
// RL7: config bits remapped into register positions
// RL8: independent read and write address generators
// RL9: 16-bit byte addresses over 64 KB
// RL10: bit 15 selects the program window
// RL11: unimplemented lower-half reads return zero
// RL12: low byte even, high byte odd
// RL13: post-increment by one byte, two word
// RL14: byte read picks lane, lands low
// RL15: shared word decode, separate lane strobes
// RL16: odd word access raises address error
// RL17: read completes, write suppressed, trap after
// RL18: byte load to register keeps high byte
// RL19: sign widen and high byte clear
// RL20: near region via 13-bit direct field
// RL21: transfer op reaches all via 16 bits
// RL22: unused special addresses read zero
// RL23: address error is one-cycle pulse with direction
// RL24: strobes combinational, both for aligned words
`timescale 1ns/100ps
module msad_top
    import msad_pkg::*;
(
    input  wire logic          mclk,          // Core clock
    input  wire logic          rst_n,         // Sync reset, active low
    input  wire logic          ce,            // Clock enable
    // Instruction pointer control
    input  wire logic          ip_advance,    // Step forward
    input  wire logic          ip_retreat,    // Step back
    input  wire logic          ip_load,       // Branch load
    input  wire logic [23:0]   ip_target,     // Branch target
    input  wire logic          vec_take,      // Vector take request, not used by the pointer
    input  wire logic          vec_alt,       // Use alternate table
    input  wire logic [6:0]    vec_num,       // Vector number
    output logic      [23:0]   instruction_pointer, // Fetch address
    output logic               ip_in_vectors, // Pointer in vector area
    output logic      [23:0]   vec_entry_addr,// Table entry address
    // Program word split
    input  wire logic [23:0]   prog_word,     // 24-bit fetched word
    output logic      [15:0]   prog_lower,    // Lower word, even addr
    output logic      [15:0]   prog_upper,    // Upper word, odd addr
    // Configuration load
    input  wire logic          cfg_valid,     // Stored words present
    input  wire logic [15:0]   cfg_word1,     // Word at top address
    input  wire logic [15:0]   cfg_word2,     // Word below top
    output logic      [23:0]   cfg_fetch_addr,// Config fetch address
    output logic      [15:0]   cfg_reg1,      // Config register 1
    output logic      [15:0]   cfg_reg2,      // Config register 2
    // Read address generator
    input  wire msad_acc_t     rd_acc,        // Read request
    input  wire msad_mod_t     rd_mod,        // Read pointer modify
    input  wire logic          rd_direct,     // Direct addressing
    input  wire logic          rd_full16,     // Transfer op 16-bit field
    input  wire logic [15:0]   rd_field,      // Direct address field
    output logic      [15:0]   rd_ptr_next,   // Modified read pointer
    output logic      [15:0]   rd_data,       // Read data
    output logic               rd_to_window,  // Routed to program window
    input  wire logic [15:0]   window_rdata,  // Window read data
    input  wire logic [15:0]   sfr_rdata,     // Special register data
    input  wire logic          sfr_hit,       // Special register exists
    // Write address generator
    input  wire msad_acc_t     wr_acc,        // Write request
    input  wire msad_mod_t     wr_mod,        // Write pointer modify
    input  wire logic          wr_direct,     // Direct addressing
    input  wire logic          wr_full16,     // Transfer op 16-bit field
    input  wire logic [15:0]   wr_field,      // Direct address field
    output logic      [15:0]   wr_ptr_next,   // Modified write pointer
    output logic      [1:0]    wr_strobe,     // Lane strobes {hi,lo}
    output logic               wr_to_window,  // Write to window area
    // Working register byte handling
    input  wire logic [15:0]   wreg_old,      // Current register value
    input  wire logic [7:0]    load_byte,     // Byte being loaded
    input  wire logic          sign_widen_op, // Sign extend
    input  wire logic          clear_high_byte_op, // Zero extend
    output logic      [15:0]   wreg_new,      // Register value to write
    // Address error
    output msad_aerr_t         addr_err       // Trap pulse and direction
);

    ////////////////////////////////////////////////////////////////////
    // Instruction pointer

    logic [23:0] ip_reg;                      // Pointer state
    logic [23:0] ip_next;                     // Next pointer
    logic        cfg_pend_reg;                // Config copy pending
    wire  logic [23:0] ip_aligned_tgt;        // Branch target aligned
    wire  logic [23:0] vec_off;               // Entry offset
    wire  logic [23:0] vec_base;              // Selected table base

    // Clear bit 0 so fetch stays on lower word
    assign ip_aligned_tgt = {ip_target[23:1], 1'b0}; // RL2
    assign vec_off   = 24'({vec_num, 1'b0});
    assign vec_base  = vec_alt ? PA_AIVT_LO : PA_IVT_LO; // RL5
    assign vec_entry_addr = vec_base + vec_off; // RL5

    // Pointer next-state selection
    always_comb begin
        ip_next = ip_reg;
        if (ip_load) begin
            ip_next = ip_aligned_tgt;
        end else if (ip_advance) begin
            ip_next = ip_reg + PA_STEP; // RL2
        end else if (ip_retreat) begin
            ip_next = ip_reg - PA_STEP; // RL2
        end
    end

    // Reset starts at the jump slot
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ip_reg <= PA_RESET; // RL4
        end else if (ce) begin
            ip_reg <= ip_next;
        end
    end

    assign instruction_pointer = ip_reg;
    // Vector area flag; operand of reset jump lives here too
    assign ip_in_vectors = (ip_reg < PA_VEC_END); // RL3

    ////////////////////////////////////////////////////////////////////
    // Program word split

    // Upper byte of the upper word is not implemented
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prog_lower <= 16'h0000;
            prog_upper <= 16'h0000;
        end else if (ce) begin
            prog_lower <= prog_word[15:0];           // RL1
            prog_upper <= {8'h00, prog_word[23:16]}; // RL1
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration copy after reset

    // Pending from reset until stored words arrive
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_pend_reg <= 1'b1;
        end else if (ce && cfg_valid) begin
            cfg_pend_reg <= 1'b0; // RL6
        end
    end

    assign cfg_fetch_addr = PA_CFG_HI;

    msad_cfg_remap u_cfg (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .load      (cfg_pend_reg && cfg_valid),
        .cfg_word1 (cfg_word1),
        .cfg_word2 (cfg_word2),
        .cfg_reg1  (cfg_reg1),
        .cfg_reg2  (cfg_reg2)
    );

    ////////////////////////////////////////////////////////////////////
    // Read address generator

    wire  logic [15:0] rd_ea;                 // Read effective address
    wire  logic        rd_impl;               // In implemented RAM
    wire  logic        rd_sfr;                // In special reg area
    wire  logic [15:0] rd_word;               // Raw word
    wire  logic [15:0] rd_sel;                // Lane steered
    wire  logic        rd_misalign;           // Odd word read
    logic [15:0]       ram_q_reg;             // RAM read word
    logic [15:0]       rd_data_reg;           // Registered read data

    // Direct field: near 13-bit or transfer 16-bit
    assign rd_ea = !rd_direct ? rd_acc.addr : // RL9
                   (rd_full16 ? rd_field // RL21
                              : {3'h0, rd_field[NEAR_FIELD_W-1:0]}); // RL20
    assign rd_to_window = rd_acc.valid && rd_ea[EA_WINDOW_BIT]; // RL10
    assign rd_impl = !rd_ea[EA_WINDOW_BIT] && (rd_ea <= DA_IMPL_TOP);
    assign rd_sfr  = rd_ea <= DA_SFR_TOP;
    // Post-modify scaled by size
    assign rd_ptr_next = (rd_mod == MSAD_MOD_POSTINC) ?
                         rd_acc.addr + step_of(rd_acc.byte_op) : // RL13
                         (rd_mod == MSAD_MOD_POSTDEC) ?
                         rd_acc.addr - step_of(rd_acc.byte_op) :
                         rd_acc.addr; // RL8

    // Source word: window, special regs, RAM, or zero
    assign rd_word = rd_ea[EA_WINDOW_BIT] ? window_rdata :
                     rd_sfr ? (sfr_hit ? sfr_rdata : 16'h0000) : // RL22
                     rd_impl ? ram_q_reg : 16'h0000; // RL11

    msad_lane_strobe u_rd_lane (
        .wr_en      (1'b0),
        .byte_op    (rd_acc.byte_op),
        .addr0      (rd_ea[0]),
        .word_in    (rd_word),
        .strobe     (),
        .misalign   (rd_misalign),
        .rd_aligned (rd_sel)
    );

    ////////////////////////////////////////////////////////////////////
    // Write address generator

    wire  logic [15:0] wr_ea;                 // Write effective address
    wire  logic        wr_impl;               // In implemented RAM
    wire  logic        wr_misalign;           // Odd word write
    wire  logic [1:0]  wr_lanes;              // Raw lane strobes
    wire  logic [15:0] wr_word;               // Byte placed on its lane

    assign wr_ea = !wr_direct ? wr_acc.addr :
                   (wr_full16 ? wr_field // RL21
                              : {3'h0, wr_field[NEAR_FIELD_W-1:0]}); // RL20
    assign wr_to_window = wr_acc.valid && wr_ea[EA_WINDOW_BIT]; // RL10
    assign wr_impl = !wr_ea[EA_WINDOW_BIT] && (wr_ea <= DA_IMPL_TOP)
                     && (wr_ea > DA_SFR_TOP);
    assign wr_ptr_next = (wr_mod == MSAD_MOD_POSTINC) ?
                         wr_acc.addr + step_of(wr_acc.byte_op) : // RL13
                         (wr_mod == MSAD_MOD_POSTDEC) ?
                         wr_acc.addr - step_of(wr_acc.byte_op) :
                         wr_acc.addr; // RL8
    assign wr_word = wr_acc.byte_op ?
                     {wr_acc.wdata[7:0], wr_acc.wdata[7:0]} :
                     wr_acc.wdata; // RL12

    msad_lane_strobe u_wr_lane (
        .wr_en      (wr_acc.valid),
        .byte_op    (wr_acc.byte_op),
        .addr0      (wr_ea[0]),
        .word_in    (16'h0000),
        .strobe     (wr_lanes),
        .misalign   (wr_misalign),
        .rd_aligned ()
    );

    // Misaligned write is suppressed
    assign wr_strobe = wr_misalign ? 2'h0 : wr_lanes; // RL17 RL24

    ////////////////////////////////////////////////////////////////////
    // Data RAM, 8 KB as two byte lanes

    logic [7:0] ram_lo [RAM_WORDS];           // Even bytes
    logic [7:0] ram_hi [RAM_WORDS];           // Odd bytes
    wire  logic [RAM_AW-1:0] rd_idx;          // Read word index
    wire  logic [RAM_AW-1:0] wr_idx;          // Write word index

    assign rd_idx = word_index(rd_ea); // RL15
    assign wr_idx = word_index(wr_ea); // RL15

    // Lane writes share one word index
    always_ff @(posedge mclk) begin
        if (ce && wr_impl && wr_strobe[0]) begin
            ram_lo[wr_idx] <= wr_word[7:0]; // RL15
        end
        if (ce && wr_impl && wr_strobe[1]) begin
            ram_hi[wr_idx] <= wr_word[15:8]; // RL15
        end
    end

    // Asynchronous word fetch, registered with the access
    assign ram_q_reg = {ram_hi[rd_idx], ram_lo[rd_idx]};

    // Read data from flip-flops, valid cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data_reg <= 16'h0000;
        end else if (ce && rd_acc.valid) begin
            rd_data_reg <= rd_sel; // RL14 RL17
        end
    end

    assign rd_data = rd_data_reg;

    ////////////////////////////////////////////////////////////////////
    // Working register byte handling

    // Priority: sign widen, clear high, else byte load
    assign wreg_new = sign_widen_op ?
                      {{BYTE_W{wreg_old[7]}}, wreg_old[7:0]} : // RL19
                      clear_high_byte_op ?
                      {8'h00, wreg_old[7:0]} : // RL19
                      {wreg_old[15:8], load_byte}; // RL18

    ////////////////////////////////////////////////////////////////////
    // Address error trap

    logic       aerr_reg;                     // Pulse
    logic       aerr_wr_reg;                  // Direction
    wire  logic aerr_rd_ev;                   // Odd word read
    wire  logic aerr_wr_ev;                   // Odd word write

    assign aerr_rd_ev = rd_acc.valid && rd_misalign; // RL16
    assign aerr_wr_ev = wr_acc.valid && wr_misalign; // RL16

    // Trap raised after the access cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aerr_reg    <= 1'b0;
            aerr_wr_reg <= 1'b0;
        end else if (ce) begin
            aerr_reg    <= aerr_rd_ev || aerr_wr_ev; // RL17 RL23
            aerr_wr_reg <= aerr_wr_ev; // RL23
        end
    end

    assign addr_err = '{pulse: aerr_reg, is_write: aerr_wr_reg};

endmodule

// ==== include/msad_pkg.sv ====
// Purpose: Shared constants and carriers for the memory space decode block
// Assumes: 16-bit data space, 24-bit program space, one core clock
// Notes:   All addresses and field positions live here by name
package msad_pkg;

    // Program space
    localparam int          PA_W          = 24;           // Program address
    localparam logic [23:0] PA_RESET      = 24'h000000;   // Reset fetch
    localparam logic [23:0] PA_JUMP_DEST  = 24'h000002;   // Jump operand
    localparam logic [23:0] PA_IVT_LO     = 24'h000004;   // Primary table
    localparam logic [23:0] PA_IVT_HI     = 24'h0000FF;
    localparam logic [23:0] PA_AIVT_LO    = 24'h000100;   // Alternate table
    localparam logic [23:0] PA_AIVT_HI    = 24'h0001FF;
    localparam logic [23:0] PA_VEC_END    = 24'h000200;   // End of vectors
    localparam logic [23:0] PA_STEP       = 24'h000002;   // Sequential step
    localparam logic [23:0] PA_CFG_HI     = 24'h0157FE;   // Top config word
    localparam logic [23:0] PA_CFG_LO     = 24'h0157FC;   // Next config word
    localparam logic [23:0] PA_VEC_STRIDE = 24'h000002;   // Vector stride
    localparam int          CFG_W         = 16;           // Stored cfg width

    // Data space
    localparam int          DA_W          = 16;
    localparam int          DW            = 16;
    localparam int          BYTE_W        = 8;
    localparam int          EA_WINDOW_BIT = 15;           // Window select
    localparam logic [15:0] DA_IMPL_TOP   = 16'h1FFF;     // 8 KB implemented
    localparam logic [15:0] DA_SFR_TOP    = 16'h07FF;     // Special regs
    localparam logic [15:0] DA_NEAR_TOP   = 16'h1FFF;     // Near region
    localparam int          NEAR_FIELD_W  = 13;
    localparam int          RAM_WORDS     = 4096;         // 8 KB of words
    localparam int          RAM_AW        = 12;
    localparam logic [15:0] STEP_BYTE     = 16'h0001;
    localparam logic [15:0] STEP_WORD     = 16'h0002;

    // Config register images loaded at reset, before the copy
    localparam logic [15:0] CFG1_RESET    = 16'h0000;
    localparam logic [15:0] CFG2_RESET    = 16'h0000;

    // Pointer modify modes
    typedef enum logic [1:0] {
        MSAD_MOD_NONE,
        MSAD_MOD_POSTINC,
        MSAD_MOD_POSTDEC
    } msad_mod_t;

    // One data access from an address generator
    typedef struct packed {
        logic        valid;       // Access this cycle
        logic        byte_op;     // Byte sized
        logic [15:0] addr;        // Byte effective address
        logic [15:0] wdata;       // Write data, byte in low lane
    } msad_acc_t;

    // Address error event
    typedef struct packed {
        logic pulse;              // One-cycle trap request
        logic is_write;           // Faulting access was a write
    } msad_aerr_t;

    // Word address of a byte address
    function automatic logic [RAM_AW-1:0] word_index(input logic [15:0] a);
        return a[RAM_AW:1];
    endfunction

    // Step size for byte or word pointer modification
    function automatic logic [15:0] step_of(input logic byte_op);
        return byte_op ? STEP_BYTE : STEP_WORD;
    endfunction

endpackage

// ==== rtl/msad_lane_strobe.sv ====
// Purpose: Byte lane write strobes and read byte steering
// Assumes: Low byte at even address, high byte at odd address
// Notes:   Purely combinational
`timescale 1ns/100ps
module msad_lane_strobe
    import msad_pkg::*;
(
    input  wire logic          wr_en,      // Write requested
    input  wire logic          byte_op,    // Byte sized
    input  wire logic          addr0,      // Address bit 0
    input  wire logic [15:0]   word_in,    // Whole word read
    output logic      [1:0]    strobe,     // Lane strobes {hi,lo}
    output logic               misalign,   // Word at odd address
    output logic      [15:0]   rd_aligned  // Byte moved to low lane
);

    wire logic lo_sel;                     // Low lane picked
    wire logic hi_sel;                     // High lane picked

    // Misaligned word access
    assign misalign   = !byte_op && addr0; // RL16
    // Lane selects
    assign lo_sel     = byte_op ? !addr0 : !addr0; // RL12
    assign hi_sel     = byte_op ? addr0 : !addr0;
    // Both lanes only for aligned word writes
    assign strobe     = wr_en ? {hi_sel, lo_sel} : 2'h0; // RL15 RL24
    // Byte read selects by address bit 0 onto low lane
    assign rd_aligned = !byte_op ? word_in :
                        (addr0 ? {8'h00, word_in[15:8]}
                               : {8'h00, word_in[7:0]}); // RL14

endmodule

// ==== rtl/msad_cfg_remap.sv ====
// Purpose: Reset-time copy of stored configuration words
// Assumes: Stored words come from top of program memory
// Notes:   Packed bit order differs from register bit order
`timescale 1ns/100ps
module msad_cfg_remap
    import msad_pkg::*;
(
    input  wire logic          mclk,       // Core clock
    input  wire logic          rst_n,      // Sync reset, active low
    input  wire logic          ce,         // Clock enable
    input  wire logic          load,       // Copy strobe
    input  wire logic [15:0]   cfg_word1,  // Stored word at top address
    input  wire logic [15:0]   cfg_word2,  // Stored word below it
    output logic      [15:0]   cfg_reg1,   // Register image 1
    output logic      [15:0]   cfg_reg2    // Register image 2
);

    wire logic [15:0] map1;                // Remapped word 1
    wire logic [15:0] map2;                // Remapped word 2

    // Reverse bit order within each byte as the register layout
    function automatic logic [15:0] remap(input logic [15:0] w);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < BYTE_W; i++) begin
            r[i]          = w[BYTE_W-1-i];
            r[BYTE_W + i] = w[DW-1-i];
        end
        return r;
    endfunction

    assign map1 = remap(cfg_word1); // RL7
    assign map2 = remap(cfg_word2); // RL7

    // Load on the copy strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_reg1 <= CFG1_RESET;
            cfg_reg2 <= CFG2_RESET;
        end else if (ce && load) begin
            cfg_reg1 <= map1; // RL6
            cfg_reg2 <= map2; // RL6
        end
    end

endmodule

// ==== verif/msad_sva.sv ====
// Purpose: Port checker for the decode top
// Assumes: One clock, sync active-low reset
// Notes:   Bound to every msad_top
`timescale 1ns/100ps
module msad_sva
    import msad_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        ip_advance,
    input wire logic        ip_load,
    input wire logic [23:0] instruction_pointer,
    input wire logic        ip_in_vectors,
    input wire logic [23:0] prog_word,
    input wire logic [15:0] prog_upper,
    input wire msad_acc_t   rd_acc,
    input wire logic [15:0] rd_data,
    input wire logic        rd_to_window,
    input wire msad_acc_t   wr_acc,
    input wire logic [1:0]  wr_strobe,
    input wire msad_aerr_t  addr_err
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Misaligned word accesses this cycle
    wire rd_bad  = ce & rd_acc.valid & ~rd_acc.byte_op & rd_acc.addr[0];
    wire wr_bad  = ce & wr_acc.valid & ~wr_acc.byte_op & wr_acc.addr[0];
    logic [7:0] up_q; // Upper fetch byte one cycle back
    always_ff @(posedge mclk) up_q <= prog_word[23:16];
    property p_rst_ip; $rose(rst_n) |-> instruction_pointer == 24'h000000;
    endproperty
    a_rst_ip: assert property (p_rst_ip) else $error("ip not 0");
    property p_step; ce && ip_advance && !ip_load |=>
        instruction_pointer == $past(instruction_pointer) + 24'h000002;
    endproperty
    a_step: assert property (p_step) else $error("ip step bad");
    property p_vec; ip_in_vectors == (instruction_pointer < 24'h000200);
    endproperty
    a_vec: assert property (p_vec) else $error("vector flag bad");
    property p_up; ce |=> prog_upper == {8'h00, up_q}; endproperty
    a_up: assert property (p_up) else $error("upper word bad");
    property p_rderr; rd_bad && !wr_bad |=> addr_err == 2'h2; endproperty
    a_rderr: assert property (p_rderr) else $error("read trap bad");
    property p_wrerr; wr_bad |=> addr_err == 2'h3; endproperty
    a_wrerr: assert property (p_wrerr) else $error("write trap bad");
    property p_cause; addr_err.pulse |-> $past(rd_bad | wr_bad); endproperty
    a_cause: assert property (p_cause) else $error("spurious trap");
    property p_stb; wr_acc.valid |-> wr_strobe == (wr_acc.byte_op ?
        (wr_acc.addr[0] ? 2'h2 : 2'h1) : (wr_acc.addr[0] ? 2'h0 : 2'h3));
    endproperty
    a_stb: assert property (p_stb) else $error("strobe bad");
    property p_bhi; ce && rd_acc.valid && rd_acc.byte_op |=>
        rd_data[15:8] == 8'h00;
    endproperty
    a_bhi: assert property (p_bhi) else $error("byte high lane");
    property p_win; rd_acc.valid |-> rd_to_window == rd_acc.addr[15];
    endproperty
    a_win: assert property (p_win) else $error("window route");
    c_wtrap: cover property (addr_err.pulse && addr_err.is_write);
    c_brd: cover property (rd_acc.valid && rd_acc.byte_op);
    c_adv: cover property (ip_advance && !ip_load);
endmodule
bind msad_top msad_sva i_sva (.*);

// ==== verif/msad_src_model.sv ====
// Purpose: Window and special register sources for reads
// Assumes: One special register at 0020h
// Notes:   Unused data churns every cycle
`timescale 1ns/100ps
module msad_src_model
    import msad_pkg::*;
(
    input  wire logic      mclk,
    input  wire msad_acc_t rd_acc,
    output logic [15:0]    window_rdata,
    output logic           sfr_hit,
    output logic [15:0]    sfr_rdata
);
    logic [15:0] churn = 16'h0000; // Junk pattern
    always_ff @(posedge mclk) churn <= churn + 16'h3C5B;
    assign sfr_hit = rd_acc.valid && rd_acc.addr[15:1] == 15'h0010;
    assign sfr_rdata = sfr_hit ? 16'h5AA5 : ~churn;
    assign window_rdata = rd_acc.addr[15] ? {rd_acc.addr[7:0], 8'hC3} : churn;
endmodule

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the decode top
// Assumes: Inputs change on falling edges
// Notes:   Source model answers window and special reads
`timescale 1ns/100ps
module tb
    import msad_pkg::*;
;
    logic        mclk, rst_n, ce, ip_advance, ip_retreat, ip_load, vec_take;
    logic        vec_alt, cfg_valid, rd_direct, rd_full16, wr_direct;
    logic        wr_full16, sign_widen_op, clear_high_byte_op, sfr_hit;
    logic        rd_to_window, wr_to_window, ip_in_vectors;
    logic [1:0]  wr_strobe;
    logic [6:0]  vec_num;
    logic [7:0]  load_byte;
    logic [15:0] prog_lower, prog_upper, cfg_word1, cfg_word2, cfg_reg1;
    logic [15:0] cfg_reg2, rd_ptr_next, rd_data, window_rdata, sfr_rdata;
    logic [15:0] rd_field, wr_field, wr_ptr_next, wreg_old, wreg_new;
    logic [23:0] ip_target, instruction_pointer, vec_entry_addr;
    logic [23:0] prog_word, cfg_fetch_addr;
    msad_acc_t   rd_acc, wr_acc;
    msad_mod_t   rd_mod = MSAD_MOD_NONE, wr_mod = MSAD_MOD_NONE;
    msad_aerr_t  addr_err;
    int          fail_count, check_count, cycles;
    msad_top i_dut (.*);
    msad_src_model i_src (.*);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [39:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, d, input logic b, s1, s0);
        @(negedge mclk);
        wr_acc = '{1'b1, b, a, d};
        #1 chk(wr_strobe, {s1, s0});
        @(negedge mclk);
        wr_acc.valid = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic b, input int e);
        @(negedge mclk);
        rd_acc = '{1'b1, b, a, 16'h0000};
        @(negedge mclk);
        rd_acc.valid = 1'b0;
        chk(rd_data, e[15:0]);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, ip_advance, ip_retreat, ip_load, vec_take, vec_alt} = '0;
        {cfg_valid, rd_direct, rd_full16, wr_direct, wr_full16} = '0;
        {sign_widen_op, clear_high_byte_op, rd_acc, wr_acc} = '0;
        {vec_num, load_byte, ip_target, prog_word, cfg_word1} = '0;
        {cfg_word2, rd_field, wr_field, wreg_old} = '0;
        ce = 1'b1;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        chk(instruction_pointer, 24'h000000);
        chk(cfg_fetch_addr, 24'h0157FE);
        {cfg_word1, cfg_word2, cfg_valid} = {16'h0180, 16'h0F00, 1'b1};
        @(negedge mclk);
        chk({cfg_reg1, cfg_reg2}, {16'h8001, 16'hF000});
        cfg_word1 = 16'hFFFF;
        @(negedge mclk);
        chk(cfg_reg1, 16'h8001);
        {ip_advance, prog_word} = {1'b1, 24'hABCDEF};
        repeat (3) @(negedge mclk);
        {ip_advance, ip_retreat} = 2'h1;
        chk({prog_upper, prog_lower}, 32'h00ABCDEF);
        chk(instruction_pointer, 24'h000006);
        @(negedge mclk);
        {ip_retreat, ip_load, ip_advance} = 3'h3;
        chk(instruction_pointer, 24'h000004);
        ip_target = 24'h000201;
        @(negedge mclk);
        {ip_load, ce, vec_num} = {2'h0, 7'h7D};
        chk({ip_in_vectors, instruction_pointer}, 25'h0000200);
        @(negedge mclk);
        chk(instruction_pointer, 24'h000200);
        chk(vec_entry_addr, 24'h0000FE);
        {ce, ip_advance, vec_alt} = 3'h5;
        #1 chk(vec_entry_addr, 24'h0001FA);
        wr(16'h0800, 16'h1234, 1'b0, 1'b1, 1'b1);
        rd(16'h0800, 1'b0, 'h1234);
        wr(16'h0801, 16'h77AB, 1'b1, 1'b1, 1'b0);
        rd(16'h0800, 1'b0, 'hAB34);
        rd(16'h0801, 1'b1, 'h00AB);
        wr(16'h0802, 16'h5678, 1'b0, 1'b1, 1'b1);
        wr(16'h0803, 16'hFFFF, 1'b0, 1'b0, 1'b0);
        chk(addr_err, 2'h3);
        rd(16'h0802, 1'b0, 'h5678);
        rd(16'h2000, 1'b0, 'h0000);
        rd(16'h7FFF, 1'b1, 'h0000);
        rd(16'h0040, 1'b0, 'h0000);
        rd(16'h0020, 1'b0, 'h5AA5);
        rd(16'h8012, 1'b0, 'h12C3);
        {rd_direct, rd_field} = {1'b1, 16'hE800};
        rd(16'h2000, 1'b0, 'hAB34);
        {rd_full16, rd_field} = {1'b1, 16'h0802};
        rd(16'h2000, 1'b0, 'h5678);
        @(negedge mclk);
        rd_mod = MSAD_MOD_POSTINC;
        wr_mod = MSAD_MOD_POSTDEC;
        rd_acc = '{1'b1, 1'b1, 16'h0810, 16'h0000};
        wr_acc = '{1'b1, 1'b0, 16'h8900, 16'h0000};
        #1 chk({wr_to_window, rd_ptr_next, wr_ptr_next},
               33'h1081188FE);
        {rd_acc, wr_acc, wreg_old, load_byte} = {68'h0, 16'h12F0, 8'h85};
        #1 chk(wreg_new, 16'h1285);
        sign_widen_op = 1'b1;
        #1 chk(wreg_new, 16'hFFF0);
        {sign_widen_op, clear_high_byte_op} = 2'h1;
        #1 chk(wreg_new, 16'h00F0);
        print_verdict();
    end
endmodule
